// ---- dpcs_seq.sv ----
// power state, burst and clock-change sequencer of a ddr2 device
`default_nettype none
module dpcs_seq
	import dpcs_pkg::*;
#(
	parameter int BANKS = DPCS_BANKS,
	parameter logic [7:0] DLL_LOCK_CYC = DPCS_DLL_LOCK_CYC
)
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic cke,
	input wire logic odt,
	input wire dpcs_cmd_t cmd,
	input wire logic initDone,
	output logic inPowerDown,
	output logic inPrechargePd,
	output logic burstActive,
	output logic dllLocked,
	output logic ready,
	output logic contentsLost,
	output logic protocolError
);
	// ************************************************************
	// decode
	// ************************************************************
	dpcs_dec_t dec;
	dpcs_cmd_decode u_dec
	(
		.cmd(cmd),
		.dec(dec)
	);

	// ************************************************************
	// state
	// ************************************************************
	dpcs_state_t state_reg, state_next;
	logic [BANKS-1:0] open_reg, open_next;
	logic [3:0] burst_reg, burst_next;
	logic [7:0] lock_reg, lock_next;
	logic lost_reg, lost_next;
	logic err_reg, err_next;
	logic dllOk_reg, dllOk_next;
	logic pdOut_reg, pdOut_next;
	logic prePdOut_reg, prePdOut_next;
	logic busyOp;
	logic dllResetCmd;

	assign busyOp = (burst_reg != 4'h0);
	assign dllResetCmd = dec.mrs && (cmd.bank == DPCS_BA_EMR) && cmd.addr[DPCS_DLL_RESET_BIT];

	always_comb
	begin
		state_next = state_reg;
		open_next = open_reg;
		burst_next = burst_reg;
		lock_next = lock_reg;
		lost_next = lost_reg;
		err_next = err_reg;
		dllOk_next = dllOk_reg;
		case (state_reg)
			DPCS_ACTIVE:
			begin
				// nops count the burst down rather than ending it
				if (busyOp)
					burst_next = burst_reg - 4'h1;
				if (!cke && busyOp)
				begin
					// cke may not fall mid-burst; the array is no longer trusted
					lost_next = 1'b1;
					state_next = DPCS_LOST;
				end
				else if (!cke && dec.idle)
				begin
					if (open_reg == '0)
					begin
						// dll is switched off as precharge power-down is entered
						state_next = DPCS_PRE_PD;
						dllOk_next = 1'b0;
					end
					else
						state_next = DPCS_ACT_PD;
				end
				else if (cke)
				begin
					if ((dec.read || dec.write) && dllOk_reg)
					begin
						if (busyOp)
							err_next = 1'b1;
						burst_next = DPCS_BURST_CYCLES;
					end
					if (dec.act)
						open_next = open_reg | (BANKS'(1) << cmd.bank);
					if (dec.pre)
						open_next = cmd.addr[DPCS_AP_BIT] ? '0 : (open_reg & ~(BANKS'(1) << cmd.bank));
				end
			end
			DPCS_PRE_PD:
			begin
				// the dll is off here, so a clock change is allowed
				dllOk_next = 1'b0;
				if (cke && dec.idle)
					state_next = DPCS_DLL_RELOCK;
				if (odt)
					err_next = 1'b1;
			end
			DPCS_ACT_PD:
			begin
				if (cke && dec.idle)
					state_next = DPCS_ACTIVE;
			end
			DPCS_DLL_RELOCK:
			begin
				if (dllResetCmd)
					lock_next = DLL_LOCK_CYC;
				else if (lock_reg != 8'h0)
					lock_next = lock_reg - 8'h1;
				if (odt)
					err_next = 1'b1;
				if (lock_reg == 8'h1)
				begin
					dllOk_next = 1'b1;
					state_next = DPCS_ACTIVE;
				end
			end
			default:
			begin
				// only a fresh initialisation brings the device back
				open_next = '0;
				burst_next = 4'h0;
				if (cke && initDone)
				begin
					lost_next = 1'b0;
					dllOk_next = 1'b1;
					state_next = DPCS_ACTIVE;
				end
			end
		endcase
		pdOut_next = (state_next == DPCS_PRE_PD) || (state_next == DPCS_ACT_PD);
		prePdOut_next = (state_next == DPCS_PRE_PD);
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_reg <= DPCS_ACTIVE;
			open_reg <= '0;
			burst_reg <= 4'h0;
			lock_reg <= 8'h0;
			lost_reg <= 1'b0;
			err_reg <= 1'b0;
			dllOk_reg <= 1'b1;
			pdOut_reg <= 1'b0;
			prePdOut_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			open_reg <= open_next;
			burst_reg <= burst_next;
			lock_reg <= lock_next;
			lost_reg <= lost_next;
			err_reg <= err_next;
			dllOk_reg <= dllOk_next;
			pdOut_reg <= pdOut_next;
			prePdOut_reg <= prePdOut_next;
		end
	end

	assign inPowerDown = pdOut_reg;
	assign inPrechargePd = prePdOut_reg;
	assign burstActive = busyOp;
	assign dllLocked = dllOk_reg;
	assign ready = (state_reg == DPCS_ACTIVE) && dllOk_reg && !lost_reg;
	assign contentsLost = lost_reg;
	assign protocolError = err_reg;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	sequence s_idleLow;
		(state_reg == DPCS_ACTIVE) && !busyOp && !cke && dec.idle;
	endsequence
	sequence s_exitPd;
		(state_reg == DPCS_PRE_PD) && cke && dec.idle;
	endsequence

	a_pd_entry_taken: assert property (s_idleLow |=> inPowerDown)
		else $error("power-down not entered");
	a_pd_kind_chosen: assert property (s_idleLow and (open_reg == '0) |=> inPrechargePd)
		else $error("wrong power-down kind");
	a_pd_exit_taken: assert property (s_exitPd |=> (state_reg == DPCS_DLL_RELOCK) && !inPowerDown)
		else $error("power-down not left");
	a_lost_on_drop: assert property ((state_reg == DPCS_ACTIVE) && busyOp && !cke |=> contentsLost)
		else $error("cke drop not flagged");
	a_nop_keeps_burst: assert property (busyOp && cke && dec.nop |=> burst_reg == $past(burst_reg) - 4'h1)
		else $error("nop ended burst");
	a_deselect_ignores: assert property (cmd.csN |-> !dec.nop && !dec.read && !dec.write && dec.idle)
		else $error("deselect decoded as command");
	a_nop_decoded: assert property (!cmd.csN && cmd.rasN && cmd.casN && cmd.weN |-> dec.nop)
		else $error("nop not decoded");
	a_relock_ready: assert property ((state_reg == DPCS_DLL_RELOCK) && (lock_reg == 8'h1) && !dllResetCmd
		|=> ready)
		else $error("not ready after lock");
	a_odt_relock: assert property ((state_reg == DPCS_DLL_RELOCK) && odt |=> protocolError)
		else $error("odt during relock unflagged");
endmodule // dpcs_seq
`default_nettype wire

// ---- dpcs_pkg.sv ----
// package for the ddr2 power-down and clock-change sequencer
`default_nettype none
package dpcs_pkg;
	// ************************************************************
	// command encodings and states
	// ************************************************************
	localparam int DPCS_BANKS = 4;
	localparam int DPCS_BURST_W = 4;
	localparam logic [2:0] DPCS_CMD_NOP = 3'h7;
	localparam logic [2:0] DPCS_CMD_READ = 3'h5;
	localparam logic [2:0] DPCS_CMD_WRITE = 3'h4;
	localparam logic [2:0] DPCS_CMD_ACT = 3'h3;
	localparam logic [2:0] DPCS_CMD_PRE = 3'h2;
	localparam logic [2:0] DPCS_CMD_MRS = 3'h0;
	localparam logic [3:0] DPCS_BURST_CYCLES = 4'h2;
	localparam int DPCS_CLK_MHZ = 125;
	localparam int DPCS_DLL_LOCK_CK = 200;
	localparam logic [7:0] DPCS_DLL_LOCK_CYC = 8'(DPCS_DLL_LOCK_CK - 1);
	localparam logic [1:0] DPCS_BA_EMR = 2'h1;
	localparam int DPCS_DLL_RESET_BIT = 0;
	// address bit that turns a precharge into precharge-all
	localparam int DPCS_AP_BIT = 10;

	typedef enum logic [2:0] {
		DPCS_ACTIVE,
		DPCS_PRE_PD,
		DPCS_ACT_PD,
		DPCS_DLL_RELOCK,
		DPCS_LOST
	} dpcs_state_t;

	typedef struct packed {
		logic csN;
		logic rasN;
		logic casN;
		logic weN;
		logic [1:0] bank;
		logic [13:0] addr;
	} dpcs_cmd_t;

	typedef struct packed {
		logic nop;
		logic deselect;
		logic idle;
		logic read;
		logic write;
		logic act;
		logic pre;
		logic mrs;
	} dpcs_dec_t;
endpackage : dpcs_pkg
`default_nettype wire

// ---- dpcs_cmd_decode.sv ----
// command decoder for the ddr2 power-down sequencer
`default_nettype none
module dpcs_cmd_decode
	import dpcs_pkg::*;
(
	input wire dpcs_cmd_t cmd,
	output dpcs_dec_t dec
);
	logic [2:0] code;
	assign code = {cmd.rasN, cmd.casN, cmd.weN};
	// deselect masks the strobes entirely
	assign dec.deselect = cmd.csN;
	assign dec.nop = !cmd.csN && (code == DPCS_CMD_NOP);
	assign dec.idle = dec.deselect || dec.nop;
	assign dec.read = !cmd.csN && (code == DPCS_CMD_READ);
	assign dec.write = !cmd.csN && (code == DPCS_CMD_WRITE);
	assign dec.act = !cmd.csN && (code == DPCS_CMD_ACT);
	assign dec.pre = !cmd.csN && (code == DPCS_CMD_PRE);
	assign dec.mrs = !cmd.csN && (code == DPCS_CMD_MRS);
endmodule // dpcs_cmd_decode
`default_nettype wire

// ---- dpcs_ctrl_model.sv ----
// memory controller model that drives command, cke, odt and init
`default_nettype none
module dpcs_ctrl_model
	import dpcs_pkg::*;
(
	input wire logic clock,
	output dpcs_cmd_t cmd,
	output logic cke,
	output logic odt,
	output logic initDone
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// command driver
	// ****************************************
	initial
	begin
		cmd = {1'h0, DPCS_CMD_NOP, 16'h0};
		cke = 1'h1;
		odt = 1'h0;
		initDone = 1'h0;
	end
	// one command per call, launched off the sampling edge
	task automatic drive(input logic cs, input logic [2:0] op, input logic [1:0] ba,
		input logic [13:0] a, input logic k, input logic init);
		@(negedge clock);
		cmd <= {cs, op, ba, a};
		cke <= k;
		initDone <= init;
		// termination never enabled by this controller
		odt <= 1'h0;
	endtask
endmodule // dpcs_ctrl_model
`default_nettype wire

// ---- dpcs_seq_tb_top.sv ----
// self-checking bench for the power-down and clock-change sequencer
`default_nettype none
module dpcs_seq_tb_top import dpcs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [6:0] PD = 7'h40, PP = 7'h20, BU = 7'h10, DL = 7'h08, RD = 7'h04, LO = 7'h02, ER = 7'h01;
	logic clock = 1'h0;
	logic reset_n = 1'h0;
	int hp = 4;
	dpcs_cmd_t cmd;
	logic cke, odt, initDone;
	logic [6:0] outs;
	logic [13:0] q[$];
	logic [15:0] lfsrState = 16'hcf78;
	logic [15:0] r;
	int errCount = 0;
	int comparisons = 0;
	event sample;
	initial
	begin
		forever #hp clock = ~clock;
	end
	dpcs_seq #(.DLL_LOCK_CYC(8'h04)) DUT (.clock(clock), .reset_n(reset_n), .cke(cke), .odt(odt),
		.cmd(cmd), .initDone(initDone), .inPowerDown(outs[6]), .inPrechargePd(outs[5]),
		.burstActive(outs[4]), .dllLocked(outs[3]), .ready(outs[2]), .contentsLost(outs[1]),
		.protocolError(outs[0]));
	dpcs_ctrl_model ctl (.clock(clock), .cmd(cmd), .cke(cke), .odt(odt), .initDone(initDone));
	function automatic logic [15:0] lfsr();
		lfsrState = {lfsrState[14:0], lfsrState[15] ^ lfsrState[13] ^ lfsrState[12] ^ lfsrState[10]};
		return lfsrState;
	endfunction
	task automatic check(input string name, input logic [6:0] seen, input logic [6:0] expv);
		comparisons++;
		if (seen !== expv)
		begin
			errCount++;
			$display("CHECK FAILED %s expected %h seen %h", name, expv, seen);
		end
	endtask
	// note the masked expectation; the monitor compares it
	task automatic ex(input logic [6:0] m, input logic [6:0] e);
		#1;
		q.push_back({m, e});
		->sample;
	endtask
	task automatic nop(input logic k);
		ctl.drive(1'h0, DPCS_CMD_NOP, 2'h0, 14'h0, k, 1'h0);
	endtask
	task automatic finish_test();
		$display("errors %0d comparisons %0d", errCount, comparisons);
		if (errCount == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		logic [13:0] n;
		forever
		begin
			@(sample);
			n = q.pop_front();
			check("outputs", outs & n[13:7], n[6:0]);
		end
	end
	initial
	begin
		#6000;
		errCount++;
		finish_test();
	end
	// ****************************************
	// stimulus
	// ****************************************
	initial
	begin
		repeat (4) @(negedge clock);
		ex(7'h7f, 7'h0c);
		reset_n = 1'h1;
		ctl.drive(1'h0, DPCS_CMD_READ, 2'h0, 14'h0, 1'h1, 1'h0);
		nop(1'h1);
		ex(BU, BU);
		nop(1'h1);
		ex(BU, BU);
		nop(1'h1);
		nop(1'h1);
		ex(BU, 7'h0);
		repeat (6)
		begin
			r = lfsr();
			ctl.drive(1'h1, r[2:0], r[4:3], r[15:2], 1'h1, 1'h0);
		end
		nop(1'h1);
		ex(BU | ER | PD, 7'h0);
		nop(1'h0);
		nop(1'h0);
		ex(PD | PP | DL | RD, PD | PP);
		// three clocks at cke low before the rate moves, then a slower stable clock
		nop(1'h0);
		hp = 5;
		repeat (4) nop(1'h0);
		nop(1'h1);
		nop(1'h1);
		ex(PD | DL | RD, 7'h0);
		ctl.drive(1'h0, DPCS_CMD_MRS, DPCS_BA_EMR, 14'(1 << DPCS_DLL_RESET_BIT), 1'h1, 1'h0);
		ctl.drive(1'h0, DPCS_CMD_READ, 2'h0, 14'h0, 1'h1, 1'h0);
		nop(1'h1);
		ex(BU | RD, 7'h0);
		// plain mode set for the new rate; must not restart the relock count
		ctl.drive(1'h0, DPCS_CMD_MRS, 2'h0, 14'h0, 1'h1, 1'h0);
		repeat (5) nop(1'h1);
		ex(RD | DL | PD, RD | DL);
		ctl.drive(1'h0, DPCS_CMD_ACT, 2'h2, 14'(lfsr() & 16'h1fff), 1'h1, 1'h0);
		nop(1'h1);
		nop(1'h0);
		nop(1'h0);
		ex(PD | PP, PD);
		nop(1'h1);
		nop(1'h1);
		ex(PD, 7'h0);
		ctl.drive(1'h0, DPCS_CMD_PRE, 2'h2, 14'h0, 1'h1, 1'h0);
		ctl.drive(1'h0, DPCS_CMD_WRITE, 2'h0, 14'h0, 1'h1, 1'h0);
		ctl.drive(1'h0, DPCS_CMD_READ, 2'h0, 14'h0, 1'h1, 1'h0);
		nop(1'h1);
		ex(ER | BU, ER | BU);
		repeat (3) nop(1'h1);
		ctl.drive(1'h0, DPCS_CMD_READ, 2'h0, 14'h0, 1'h1, 1'h0);
		nop(1'h0);
		nop(1'h0);
		ex(LO | RD, LO);
		repeat (3) nop(1'h0);
		ctl.drive(1'h0, DPCS_CMD_NOP, 2'h0, 14'h0, 1'h1, 1'h1);
		nop(1'h1);
		ex(LO, 7'h0);
		@(negedge clock);
		finish_test();
	end
endmodule // dpcs_seq_tb_top
`default_nettype wire
